// ==== common/iprsc_map.vh ====
/*
  Register map, field positions and reset values of the interrupt priority
  and sense control block.
  Assumes a 32-bit byte address and 16-bit register data on the register port.
*/
`ifndef IPRSC_MAP_VH
`define IPRSC_MAP_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define IPRSC_ADDR_W          32
`define IPRSC_DATA_W          16
`define IPRSC_DMA_PRI_ADDR    32'hFFFF834C
`define IPRSC_T01_PRI_ADDR    32'h0FFF834E
`define IPRSC_T2_PRI_ADDR     32'hFFFF8350
`define IPRSC_SER_PRI_ADDR    32'hFFFF8352
`define IPRSC_CONV_PRI_ADDR   32'hFFFF8354
`define IPRSC_WB_PRI_ADDR     32'hFFFF8356
`define IPRSC_ICTRL_ADDR      32'hFFFF8358
`define IPRSC_REQST_ADDR      32'hFFFF835A
`define IPRSC_EVST_ADDR       32'hFFFF8360
`define IPRSC_EVMASK_ADDR     32'hFFFF8362

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IPRSC_LVL_W           4
`define IPRSC_NSRC            14
`define IPRSC_NEXT            6
`define IPRSC_NMI_LEVEL_BIT   15
`define IPRSC_NMI_EDGE_BIT    8
`define IPRSC_EV_NMI_BIT      0
`define IPRSC_EV_EXT_BIT      1
`define IPRSC_EV_W            2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IPRSC_PRI_RST         16'h0000
`define IPRSC_SENSE_RST       6'h00
`define IPRSC_EV_RST          2'h0
`define IPRSC_EV_MASK_RST     2'h0
`define IPRSC_PIN_IDLE        6'h3F

`endif

// ==== hw/iprsc_arbiter.v ====
/*
  Priority resolver: picks the pending source with the highest 4-bit level.
  Assumes request levels are steady for one clock; outputs are registered.
*/
`timescale 1ns/1ps
`include "iprsc_map.vh"

module iprsc_arbiter
(
  clk,
  rst_n,
  req,
  levels,
  win_req,
  win_level,
  win_src
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire [13:0] req;
  input  wire [55:0] levels;
  output reg         win_req;
  output reg  [3:0]  win_level;
  output reg  [3:0]  win_src;

  // --------------------------------------------------------------------------
  // Compare chain
  // --------------------------------------------------------------------------
  wire [3:0] best_lvl [0:14];
  wire [3:0] best_src [0:14];

  assign best_lvl[0] = 4'h0;
  assign best_src[0] = 4'h0;

  // Strictly greater wins, so ties keep the lower index and level 0 never wins.
  genvar i;
  generate
    for (i = 0; i < 14; i = i + 1)
    begin : g_cmp
      localparam [3:0] IDX = i;
      wire [3:0] lvl_i = levels[4*i+3:4*i];
      wire       take  = req[i] && (lvl_i > best_lvl[i]);
      assign best_lvl[i+1] = take ? lvl_i : best_lvl[i];
      assign best_src[i+1] = take ? IDX : best_src[i];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // Winner is presented to the core one cycle after the requests.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      win_req   <= 1'b0;
      win_level <= 4'h0;
      win_src   <= 4'h0;
    end
    else
    begin
      win_req   <= (best_lvl[14] != 4'h0);
      win_level <= best_lvl[14];
      win_src   <= best_src[14];
    end
  end

endmodule

// ==== hw/iprsc_ctrl.v ====
/*
  Interrupt priority and sense control: priority registers, control register,
  external request flags, non-maskable edge detect and the event interrupt.
  Assumes all pin inputs are already synchronous to clk and that the register
  port issues single-cycle read and write strobes that never overlap.
*/
// Notes on behaviour
// - DMA priority: bits 15..12 channel a level, 11..8 channel b level.
// - Timer01 priority: four writable levels, timer a at top, timer b low.
// - Timer2 priority: two levels in high byte; low byte reads zero.
// - Serial priority: channel a bits 7..4, b 3..0; high byte zero.
// - Converter level 15..12, compare timers 7..4 and 3..0; 11..8 zero.
// - Watchdog and bus controller share level 15..12; rest reads zero.
// - Control bit 15 reads back the live non-maskable pin level.
// - Control bit 8 picks non-maskable edge: 0 falling, 1 rising.
// - Sense bits: 0 detects low level, 1 detects falling edge.
// - Edge flags set on fall, clear by write-0-after-read-1 or acknowledge.
`timescale 1ns/1ps
`include "iprsc_map.vh"

module iprsc_ctrl
(
  clk,
  rst_n,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  nmi_pin,
  ext_req_n,
  ext_ack,
  periph_req,
  nmi_request,
  ext_flag,
  cpu_req,
  cpu_level,
  cpu_src,
  irq
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire [31:0] addr;
  input  wire [15:0] wdata;
  input  wire        wr;
  input  wire        rd;
  output reg  [15:0] rdata;
  input  wire        nmi_pin;
  input  wire [5:0]  ext_req_n;
  input  wire [5:0]  ext_ack;
  input  wire [13:0] periph_req;
  output reg         nmi_request;
  output wire [5:0]  ext_flag;
  output wire        cpu_req;
  output wire [3:0]  cpu_level;
  output wire [3:0]  cpu_src;
  output reg         irq;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire sel_dma   = (addr == `IPRSC_DMA_PRI_ADDR);
  wire sel_t01   = (addr == `IPRSC_T01_PRI_ADDR);
  wire sel_t2    = (addr == `IPRSC_T2_PRI_ADDR);
  wire sel_ser   = (addr == `IPRSC_SER_PRI_ADDR);
  wire sel_conv  = (addr == `IPRSC_CONV_PRI_ADDR);
  wire sel_wb    = (addr == `IPRSC_WB_PRI_ADDR);
  wire sel_ictrl = (addr == `IPRSC_ICTRL_ADDR);
  wire sel_reqst = (addr == `IPRSC_REQST_ADDR);
  wire sel_evst  = (addr == `IPRSC_EVST_ADDR);
  wire sel_evmsk = (addr == `IPRSC_EVMASK_ADDR);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [7:0]  dma_pri_reg;
  reg  [15:0] t01_pri_reg;
  reg  [7:0]  t2_pri_reg;
  reg  [7:0]  ser_pri_reg;
  reg  [3:0]  conv_hi_reg;
  reg  [7:0]  conv_lo_reg;
  reg  [3:0]  wb_pri_reg;
  reg         nmi_edge_select_reg;
  reg  [5:0]  sense_reg;
  reg  [5:0]  flag_reg;
  reg  [5:0]  flag_next;
  reg  [5:0]  seen_reg;
  reg  [5:0]  pin_prev_reg;
  reg         nmi_prev_reg;
  reg  [1:0]  ev_reg;
  reg  [1:0]  ev_next;
  reg  [1:0]  ev_mask_reg;
  reg  [15:0] rdata_next;

  wire [15:0] ictrl_word;
  wire [15:0] reqst_word;
  wire [5:0]  fall;
  wire [5:0]  sw_clear;

  // --------------------------------------------------------------------------
  // Priority register writes
  // --------------------------------------------------------------------------
  // Only writable fields are stored; read-only bits have no flip-flops.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      dma_pri_reg <= 8'h00;
      t01_pri_reg <= `IPRSC_PRI_RST;
      t2_pri_reg  <= 8'h00;
      ser_pri_reg <= 8'h00;
      conv_hi_reg <= 4'h0;
      conv_lo_reg <= 8'h00;
      wb_pri_reg  <= 4'h0;
    end
    else if (wr)
    begin
      if (sel_dma)
      begin
        dma_pri_reg <= wdata[15:8];
      end
      if (sel_t01)
      begin
        t01_pri_reg <= wdata;
      end
      if (sel_t2)
      begin
        t2_pri_reg <= wdata[15:8];
      end
      if (sel_ser)
      begin
        ser_pri_reg <= wdata[7:0];
      end
      if (sel_conv)
      begin
        conv_hi_reg <= wdata[15:12];
        conv_lo_reg <= wdata[7:0];
      end
      if (sel_wb)
      begin
        wb_pri_reg <= wdata[15:12];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control register writes
  // --------------------------------------------------------------------------
  // Edge select for the non-maskable pin and sense select per request pin.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      nmi_edge_select_reg <= 1'b0;
      sense_reg           <= `IPRSC_SENSE_RST;
      ev_mask_reg         <= `IPRSC_EV_MASK_RST;
    end
    else if (wr)
    begin
      if (sel_ictrl)
      begin
        nmi_edge_select_reg <= wdata[`IPRSC_NMI_EDGE_BIT];
        sense_reg           <= {wdata[0], wdata[1], wdata[4], wdata[5], wdata[6], wdata[7]};
      end
      if (sel_evmsk)
      begin
        ev_mask_reg <= wdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Non-maskable pin edge detect
  // --------------------------------------------------------------------------
  // One-cycle request on the selected edge of the pin.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      nmi_prev_reg <= 1'b1;
      nmi_request  <= 1'b0;
    end
    else
    begin
      nmi_prev_reg <= nmi_pin;
      if (nmi_edge_select_reg)
      begin
        nmi_request <= nmi_pin & ~nmi_prev_reg;
      end
      else
      begin
        nmi_request <= ~nmi_pin & nmi_prev_reg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // External request flags
  // --------------------------------------------------------------------------
  // Pin k maps to status bit 7-k for k<4 and to bit 5-k above that.
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1)
    begin : g_ext
      localparam integer POS = (k < 4) ? (7 - k) : (5 - k);
      assign fall[k]        = pin_prev_reg[k] & ~ext_req_n[k];
      assign sw_clear[k]    = wr & sel_reqst & ~wdata[POS] & seen_reg[k];
      assign reqst_word[POS] = flag_reg[k];
      assign ictrl_word[POS] = sense_reg[k];

      // Level mode follows the pin; edge mode lets a new edge beat a clear.
      always @*
      begin
        flag_next[k] = flag_reg[k];
        if (!sense_reg[k])
        begin
          flag_next[k] = ~ext_req_n[k];
        end
        else if (fall[k])
        begin
          flag_next[k] = 1'b1;
        end
        else if (sw_clear[k] | ext_ack[k])
        begin
          flag_next[k] = 1'b0;
        end
      end

      // A read that returns 1 arms the write-0 clear until the next write to the request status register.
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          seen_reg[k] <= 1'b0;
        end
        else if (rd & sel_reqst & flag_reg[k])
        begin
          seen_reg[k] <= 1'b1;
        end
        else if (wr & sel_reqst)
        begin
          seen_reg[k] <= 1'b0;
        end
      end
    end
  endgenerate

  assign reqst_word[15:8] = 8'h00;
  assign reqst_word[3:2]  = 2'h0;
  assign ictrl_word[15]   = nmi_pin;
  assign ictrl_word[14:9] = 6'h00;
  assign ictrl_word[8]    = nmi_edge_select_reg;
  assign ictrl_word[3:2]  = 2'h0;

  // Flag and previous-pin registers.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_reg     <= 6'h00;
      pin_prev_reg <= `IPRSC_PIN_IDLE;
    end
    else
    begin
      flag_reg     <= flag_next;
      pin_prev_reg <= ext_req_n;
    end
  end

  assign ext_flag = flag_reg;

  // --------------------------------------------------------------------------
  // Event status and interrupt line
  // --------------------------------------------------------------------------
  // Events are sticky; a read clears them but a same-cycle event survives.
  always @*
  begin
    ev_next = ev_reg;
    if (rd & sel_evst)
    begin
      ev_next = 2'h0;
    end
    if (nmi_request)
    begin
      ev_next[`IPRSC_EV_NMI_BIT] = 1'b1;
    end
    if (|(fall & sense_reg))
    begin
      ev_next[`IPRSC_EV_EXT_BIT] = 1'b1;
    end
  end

  // Status register and level interrupt output.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ev_reg <= `IPRSC_EV_RST;
      irq    <= 1'b0;
    end
    else
    begin
      ev_reg <= ev_next;
      irq    <= |(ev_next & ev_mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Unmapped addresses and read-only reserved bits read as zero.
  always @*
  begin
    rdata_next = 16'h0000;
    if (sel_dma)
    begin
      rdata_next = {dma_pri_reg, 8'h00};
    end
    if (sel_t01)
    begin
      rdata_next = t01_pri_reg;
    end
    if (sel_t2)
    begin
      rdata_next = {t2_pri_reg, 8'h00};
    end
    if (sel_ser)
    begin
      rdata_next = {8'h00, ser_pri_reg};
    end
    if (sel_conv)
    begin
      rdata_next = {conv_hi_reg, 4'h0, conv_lo_reg};
    end
    if (sel_wb)
    begin
      rdata_next = {wb_pri_reg, 12'h000};
    end
    if (sel_ictrl)
    begin
      rdata_next = ictrl_word;
    end
    if (sel_reqst)
    begin
      rdata_next = reqst_word;
    end
    if (sel_evst)
    begin
      rdata_next = {14'h0000, ev_reg};
    end
    if (sel_evmsk)
    begin
      rdata_next = {14'h0000, ev_mask_reg};
    end
  end

  // Read data is valid only in the cycle after the read strobe.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata <= 16'h0000;
    end
    else if (rd)
    begin
      rdata <= rdata_next;
    end
    else
    begin
      rdata <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // Arbitration toward the core
  // --------------------------------------------------------------------------
  // Source order: dma a,b; timer a x2, b x2, c x2; serial a,b; converter;
  // compare a,b; watchdog and bus controller.
  wire [55:0] levels = {
    wb_pri_reg,
    conv_lo_reg[3:0],
    conv_lo_reg[7:4],
    conv_hi_reg,
    ser_pri_reg[3:0],
    ser_pri_reg[7:4],
    t2_pri_reg[3:0],
    t2_pri_reg[7:4],
    t01_pri_reg[3:0],
    t01_pri_reg[7:4],
    t01_pri_reg[11:8],
    t01_pri_reg[15:12],
    dma_pri_reg[3:0],
    dma_pri_reg[7:4]
  };

  iprsc_arbiter u_arb
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .req       (periph_req),
    .levels    (levels),
    .win_req   (cpu_req),
    .win_level (cpu_level),
    .win_src   (cpu_src)
  );

endmodule

// ==== tb/iprsc_ctrl_props.sv ====
/*
  Port checker of the interrupt priority and sense control block.
  Assumes the register map header and a single clock domain.
*/
`timescale 1ns/1ps
`include "iprsc_map.vh"

module iprsc_props
(
  input logic        clk,
  input logic        rst_n,
  input logic [31:0] addr,
  input logic        rd,
  input logic [15:0] rdata,
  input logic        nmi_pin,
  input logic [5:0]  ext_req_n,
  input logic [13:0] periph_req,
  input logic        nmi_request,
  input logic [5:0]  ext_flag,
  input logic        cpu_req,
  input logic [3:0]  cpu_level
);
  // ----------------------------------------------------------------------------
  // Read data, detection and arbitration relations.
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_nmi_level: assert property (rd && addr == `IPRSC_ICTRL_ADDR |=> rdata[15] == $past(nmi_pin))
    else $error("control bit 15 differs from pin");
  chk_nmi_pulse: assert property (nmi_request |-> $past(nmi_pin, 2) != $past(nmi_pin) ##1 !nmi_request)
    else $error("nmi request without edge or too long");
  chk_t2_low: assert property (rd && addr == `IPRSC_T2_PRI_ADDR |=> rdata[7:0] == 8'h00)
    else $error("timer2 low byte not zero");
  chk_ser_high: assert property (rd && addr == `IPRSC_SER_PRI_ADDR |=> rdata[15:8] == 8'h00)
    else $error("serial high byte not zero");
  chk_conv_mid: assert property (rd && addr == `IPRSC_CONV_PRI_ADDR |=> rdata[11:8] == 4'h0)
    else $error("converter bits 11..8 not zero");
  chk_wb_low: assert property (rd && addr == `IPRSC_WB_PRI_ADDR |=> rdata[11:0] == 12'h000)
    else $error("watchdog low bits not zero");
  chk_lvl_masked: assert property (!(|periph_req) [*2] |=> !cpu_req)
    else $error("request without pending source");
  chk_win_nonzero: assert property (cpu_req |-> cpu_level != 4'h0)
    else $error("winner with level zero");
  chk_flag_cause: assert property ($rose(ext_flag[0]) |-> !$past(ext_req_n[0]))
    else $error("flag rose with pin high");
endmodule

bind iprsc_ctrl iprsc_props u_iprsc_props (.clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd), .rdata(rdata),
  .nmi_pin(nmi_pin), .ext_req_n(ext_req_n), .periph_req(periph_req), .nmi_request(nmi_request),
  .ext_flag(ext_flag), .cpu_req(cpu_req), .cpu_level(cpu_level));

// ==== tb/iprsc_cpu_model.sv ====
/*
  Core model: takes one pending external request per go strobe.
  Assumes ext_flag comes from the block and go is a one-cycle strobe.
*/
`timescale 1ns/1ps

module iprsc_cpu_model
(
  input  logic       clk,
  input  logic       ack_go,
  input  logic [5:0] ext_flag,
  output logic [5:0] ext_ack
);
  // The lowest pending flag is acknowledged for exactly one cycle.
  always @(posedge clk)
    ext_ack <= ack_go ? (ext_flag & (~ext_flag + 6'h01)) : 6'h00;
endmodule

// ==== tb/test_iprsc_ctrl.sv ====
/*
  Self-checking bench of the interrupt priority and sense control block.
  Assumes the register map header, the checker and the core model.
*/
`timescale 1ns/1ps
`include "iprsc_map.vh"

module test_iprsc_ctrl;
  logic        clk, rst_n, wr, rd, nmi_pin, ack_go;
  logic [31:0] addr;
  logic [15:0] wdata, d;
  logic [5:0]  ext_req_n;
  logic [13:0] periph_req;
  wire  [15:0] rdata;
  wire  [5:0]  ext_ack, ext_flag;
  wire  [3:0]  cpu_level, cpu_src;
  wire         nmi_request, cpu_req, irq;
  int          n_errors, n_compared, best, src, k, lv;
  logic [15:0] sh [8];
  logic [31:0] ta [11] = '{`IPRSC_DMA_PRI_ADDR, `IPRSC_T01_PRI_ADDR, `IPRSC_T2_PRI_ADDR, `IPRSC_SER_PRI_ADDR,
    `IPRSC_CONV_PRI_ADDR, `IPRSC_WB_PRI_ADDR, `IPRSC_ICTRL_ADDR, `IPRSC_EVMASK_ADDR, `IPRSC_REQST_ADDR,
    `IPRSC_EVST_ADDR, 32'hFFFF835C};
  logic [15:0] tm [8] = '{16'hFF00, 16'hFFFF, 16'hFF00, 16'h00FF, 16'hF0FF, 16'hF000, 16'h01F3, 16'h0003};
  int          rr [14] = '{0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5};
  int          ss [14] = '{12, 8, 12, 8, 4, 0, 12, 8, 4, 0, 12, 4, 0, 12};

  iprsc_ctrl u_iprsc_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .nmi_pin(nmi_pin), .ext_req_n(ext_req_n), .ext_ack(ext_ack), .periph_req(periph_req),
    .nmi_request(nmi_request), .ext_flag(ext_flag), .cpu_req(cpu_req), .cpu_level(cpu_level),
    .cpu_src(cpu_src), .irq(irq));
  iprsc_cpu_model u_iprsc_cpu_model (.clk(clk), .ack_go(ack_go), .ext_flag(ext_flag), .ext_ack(ext_ack));

  // ----------------------------------------------------------------------------
  // Clock, comparison and register port tasks.
  // ----------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // The shadow keeps only the writable bits of the first eight registers in ta: priority, control and event mask.
  task automatic wreg(input int i, input logic [15:0] v);
    @(posedge clk);
    addr  <= ta[i];
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (i < 8)
      sh[i] = v & tm[i];
  endtask

  task automatic rreg(input int i);
    @(posedge clk);
    addr <= ta[i];
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Highest level wins, lower index on a tie, level zero never requests.
  task automatic arb(input logic [13:0] r);
    @(posedge clk);
    periph_req <= r;
    tick(3);
    best = 0;
    src  = 0;
    for (k = 0; k < 14; k++)
    begin
      lv = int'((sh[rr[k]] >> ss[k]) & 16'h000F);
      if (r[k] && lv > best)
      begin
        best = lv;
        src  = k;
      end
    end
    chk("cpu_req", cpu_req, best > 0);
    if (best > 0)
    begin
      chk("cpu_level", cpu_level, best);
      chk("cpu_src", cpu_src, src);
    end
  endtask

  task automatic nmi_to(input logic v, input int exp);
    @(posedge clk);
    nmi_pin <= v;
    k = 0;
    repeat (4)
    begin
      @(posedge clk);
      #1 k += nmi_request;
    end
    chk("nmi_pulses", 16'(k), 16'(exp));
  endtask

  task automatic pin0(input logic v);
    @(posedge clk);
    ext_req_n <= {5'h1F, v};
    tick(2);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------------------
  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end

  initial
  begin
    {rst_n, wr, rd, ack_go, addr, wdata, periph_req} = '0;
    nmi_pin   = 1'b1;
    ext_req_n = 6'h3F;
    void'($urandom(32'h602cdac8));
    foreach (sh[i]) sh[i] = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      rreg(i);
      chk("reset", d, (i == 6) ? 16'h8000 : 16'h0000);
    end
    repeat (6)
      for (int i = 0; i < 8; i++)
      begin
        wreg(i, 16'($urandom));
        rreg(i);
        chk("readback", d, sh[i] | ((i == 6) ? 16'h8000 : 16'h0000));
        arb(14'($urandom));
      end
    wreg(10, 16'hFFFF);
    rreg(10);
    chk("unmapped", d, 16'h0000);
    for (int i = 0; i < 6; i++) wreg(i, (i == 0) ? 16'h5500 : 16'h0000);
    arb(14'h3FFF);
    arb(14'h0000);
    wreg(1, 16'h5555);
    arb(14'h3FFC);
    // External pin 0 in level mode, then in edge mode with both ways of clearing.
    wreg(6, 16'h0000);
    wreg(7, 16'h0003);
    pin0(1'b0);
    chk("level_flag", ext_flag, 16'h0001);
    pin0(1'b1);
    chk("level_flag", ext_flag, 16'h0000);
    wreg(6, 16'h0080);
    pin0(1'b0);
    pin0(1'b1);
    chk("edge_flag", ext_flag, 16'h0001);
    wreg(8, 16'h0000);
    tick(1);
    chk("edge_flag", ext_flag, 16'h0001);
    rreg(8);
    chk("req_status", d, 16'h0080);
    wreg(8, 16'h0000);
    tick(1);
    chk("edge_flag", ext_flag, 16'h0000);
    pin0(1'b0);
    pin0(1'b1);
    @(posedge clk) ack_go <= 1'b1;
    @(posedge clk) ack_go <= 1'b0;
    tick(2);
    chk("ack_flag", ext_flag, 16'h0000);
    chk("irq", irq, 16'h0001);
    rreg(9);
    chk("event", d, 16'h0002);
    // All six pins in edge mode: bit mapping, partial clear, disarmed clear.
    wreg(6, 16'h00F3);
    @(posedge clk) ext_req_n <= 6'h00;
    @(posedge clk) ext_req_n <= 6'h3F;
    tick(1);
    chk("edge_all", ext_flag, 16'h003F);
    rreg(8);
    chk("req_status", d, 16'h00F3);
    wreg(8, 16'h00F0);
    tick(1);
    chk("part_clear", ext_flag, 16'h000F);
    wreg(8, 16'h0000);
    tick(1);
    chk("no_rearm", ext_flag, 16'h000F);
    rreg(9);
    chk("event", d, 16'h0002);
    // Non-maskable edge select, sticky event behind the mask.
    wreg(7, 16'h0000);
    nmi_to(1'b0, 1);
    chk("irq", irq, 16'h0000);
    wreg(7, 16'h0001);
    tick(2);
    chk("irq", irq, 16'h0001);
    rreg(9);
    chk("event", d, 16'h0001);
    tick(2);
    chk("irq", irq, 16'h0000);
    nmi_to(1'b1, 0);
    wreg(6, 16'h0100);
    nmi_to(1'b0, 0);
    rreg(6);
    chk("control", d, 16'h0100);
    nmi_to(1'b1, 1);
    close_out();
  end
endmodule
